// ---- hw/haptic_pkg.sv ----
// constants for the loop-tuning register bank of the haptic driver
// assumes a 40 MHz system clock and an 8-bit register access port
package haptic_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_LOOP_TUNING   = 8'h1F;
	localparam logic [7:0] ADDR_OL_PERIOD     = 8'h20;
	localparam logic [7:0] ADDR_SUPPLY        = 8'h21;
	localparam logic [7:0] ADDR_RESONANCE     = 8'h22;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int         FB_CNT_MSB         = 7;
	localparam int         FB_CNT_LSB         = 6;
	localparam int         FB_EN_BIT          = 5;
	localparam int         INTERVAL_BIT       = 4;
	localparam int         BLANK_MSB          = 3;
	localparam int         BLANK_LSB          = 2;
	localparam int         DISS_MSB           = 1;
	localparam int         DISS_LSB           = 0;
	localparam int         OL_CODE_MSB        = 6;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] LOOP_TUNING_RST    = 8'h80;
	localparam logic [7:0] OL_PERIOD_RST      = 8'h00;
	localparam logic [7:0] SUPPLY_RST         = 8'h00;
	localparam logic [7:0] RESONANCE_RST      = 8'h00;
	localparam logic [7:0] READ_ZERO          = 8'h00;

	// attempts = code + base, codes 0..3 give 3..6
	localparam logic [2:0] FB_ATTEMPT_BASE    = 3'h3;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int         CLK_PERIOD_NS      = 25;
	localparam int         STEP_SLOW_MS       = 5;
	localparam int         STEP_FAST_MS       = 1;
	localparam int         STEP_SLOW_CYC      =
		STEP_SLOW_MS * 1000000 / CLK_PERIOD_NS;
	localparam int         STEP_FAST_CYC      =
		STEP_FAST_MS * 1000000 / CLK_PERIOD_NS;
	// 98.46 us held in hundredths of a microsecond
	localparam int         OL_UNIT_US_X100    = 9846;
	localparam int         OL_UNIT_CYC        =
		OL_UNIT_US_X100 * 10 / CLK_PERIOD_NS;

	// supply scale: volts = code * 5.6 / 255
	localparam int         SUPPLY_FULL_MV     = 5600;
	localparam int         SUPPLY_CODE_MAX    = 255;

	// ----------------------------------------------------------------
	// fall-back sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		FB_IDLE   = 3'b001,
		FB_CLOSED = 3'b010,
		FB_OPEN   = 3'b100
	} fb_state_t;

endpackage

// ---- hw/sample_hold.sv ----
// register that software may write and the drive engine refreshes
// assumes samples arrive on sys_clk from the measurement logic
`timescale 1ns/100ps
module sample_hold #(
	parameter int           W       = 8,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         sys_clk,
	input  wire logic         reset,
	input  wire logic         host_load,
	input  wire logic [W-1:0] host_data,
	input  wire logic         live,
	input  wire logic         sample_valid,
	input  wire logic [W-1:0] sample_data,
	output logic      [W-1:0] value
);
	logic [W-1:0] value_ff;
	logic [W-1:0] nxt_value;

	// an empty register cannot be built
	if (W < 1) begin : g_bad_width
		$error("sample_hold: W must be at least 1");
	end

	// hardware refresh wins over a host write in the same cycle
	always_comb begin
		nxt_value = value_ff;
		if (live && sample_valid) begin
			nxt_value = sample_data;
		end else if (host_load) begin
			nxt_value = host_data;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			value_ff <= RST_VAL;
		end else begin
			value_ff <= nxt_value;
		end
	end

	assign value = value_ff;
endmodule

// ---- hw/fallback_seq.sv ----
// counts failed synchronisation attempts and latches open-loop fall-back
// assumes attempt and back-emf pulses come from the loop on sys_clk
`timescale 1ns/100ps
module fallback_seq (
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic       play_active,
	input  wire logic       lra_select,
	input  wire logic       auto_fallback_enable,
	input  wire logic [2:0] attempt_limit,
	input  wire logic       sync_attempt_fail,
	input  wire logic       bemf_detect,
	output logic            fell_back
);
	haptic_pkg::fb_state_t state_ff;
	haptic_pkg::fb_state_t nxt_state;
	logic [2:0]            fail_cnt_ff;
	logic [2:0]            nxt_fail_cnt;

	always_comb begin
		nxt_state    = state_ff;
		nxt_fail_cnt = fail_cnt_ff;
		case (state_ff)
			haptic_pkg::FB_IDLE: begin
				nxt_fail_cnt = 3'h0;
				if (play_active) nxt_state = haptic_pkg::FB_CLOSED;
			end
			haptic_pkg::FB_CLOSED: begin
				if (!play_active) begin
					nxt_state = haptic_pkg::FB_IDLE;
				end else if (bemf_detect) begin
					nxt_fail_cnt = 3'h0;
				end else if (sync_attempt_fail) begin
					nxt_fail_cnt = fail_cnt_ff + 3'h1;
					// disabled bit means closed loop forever
					if (auto_fallback_enable && lra_select &&
						nxt_fail_cnt >= attempt_limit) begin
						nxt_state = haptic_pkg::FB_OPEN;
					end
				end
			end
			haptic_pkg::FB_OPEN: begin
				// held until the waveform ends, even if re-synced
				if (!play_active) nxt_state = haptic_pkg::FB_IDLE;
			end
			default: nxt_state = haptic_pkg::FB_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_ff    <= haptic_pkg::FB_IDLE;
			fail_cnt_ff <= 3'h0;
		end else begin
			state_ff    <= nxt_state;
			fail_cnt_ff <= nxt_fail_cnt;
		end
	end

	assign fell_back = (state_ff == haptic_pkg::FB_OPEN);

	chk_fallback_cause: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(fell_back) |-> $past(auto_fallback_enable) && $past(lra_select)
		&& $past(fail_cnt_ff) + 3'h1 >= $past(attempt_limit))
		else $error("fall-back without enable or enough attempts");
	chk_fallback_hold: assert property (@(posedge sys_clk) disable iff (reset)
		fell_back && play_active |=> fell_back)
		else $error("open loop left before waveform end");
endmodule

// ---- hw/loop_tuning_regs.sv ----
// loop-tuning register bank of a haptic actuator driver
// assumes the serial slave presents decoded byte accesses on sys_clk
// and that the drive engine signals run on the same clock
//
// Overview of operation
// - two-bit code sets 3 to 6 attempts
// - enable bit permits open-loop fall-back for LRA
// - interval bit picks 5 ms or 1 ms steps
// - bits 3-2 give blanking setting upper bits
// - bits 1-0 give dissipation setting upper bits
// - open-loop period is code times 98.46 us
// - supply reading is live eight-bit voltage code
// - readings refresh only during waveform playback
// - resonance period code reported in 98.46 us units
`timescale 1ns/100ps
module loop_tuning_regs #(
	parameter int STEP_SLOW_CYCLES = haptic_pkg::STEP_SLOW_CYC,
	parameter int STEP_FAST_CYCLES = haptic_pkg::STEP_FAST_CYC,
	parameter int OL_UNIT_CYCLES   = haptic_pkg::OL_UNIT_CYC
) (
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       play_active,
	input  wire logic       lra_select,
	input  wire logic       open_loop_select,
	input  wire logic       sync_attempt_fail,
	input  wire logic       bemf_detect,
	input  wire logic [7:0] supply_sample,
	input  wire logic       supply_sample_valid,
	input  wire logic [7:0] resonance_sample,
	input  wire logic       resonance_sample_valid,
	input  wire logic [1:0] blank_low_bits,
	input  wire logic [1:0] diss_low_bits,
	output logic      [2:0] fallback_attempt_count,
	output logic            auto_fallback_enable,
	output logic            open_loop_drive,
	output logic      [6:0] open_loop_period_code,
	output logic            ol_period_tick,
	output logic            playback_tick,
	output logic      [3:0] blank_window_setting,
	output logic      [3:0] dissipation_window_setting
);
	localparam int STEP_W = $clog2(STEP_SLOW_CYCLES + 1);
	localparam int UNIT_W = $clog2(OL_UNIT_CYCLES + 1);

	if (STEP_FAST_CYCLES < 1 ||
		STEP_SLOW_CYCLES < STEP_FAST_CYCLES) begin : g_bad_step
		$error("loop_tuning_regs: bad playback step counts");
	end
	if (OL_UNIT_CYCLES < 1) begin : g_bad_unit
		$error("loop_tuning_regs: bad open-loop unit count");
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	logic [7:0] tuning_ff;
	logic [7:0] nxt_tuning;
	logic [6:0] ol_code_ff;
	logic [6:0] nxt_ol_code;
	logic [7:0] reg_rdata_ff;
	logic [7:0] nxt_rdata;
	logic [7:0] supply_code;
	logic [7:0] resonance_code;
	logic       wr_supply;
	logic       wr_resonance;

	assign wr_supply    = reg_wr && reg_addr == haptic_pkg::ADDR_SUPPLY;
	assign wr_resonance = reg_wr && reg_addr == haptic_pkg::ADDR_RESONANCE;

	always_comb begin
		nxt_tuning  = tuning_ff;
		nxt_ol_code = ol_code_ff;
		if (reg_wr && reg_addr == haptic_pkg::ADDR_LOOP_TUNING) begin
			nxt_tuning = reg_wdata;
		end
		// top bit is reserved and never stored
		if (reg_wr && reg_addr == haptic_pkg::ADDR_OL_PERIOD) begin
			nxt_ol_code = reg_wdata[haptic_pkg::OL_CODE_MSB:0];
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	always_comb begin
		nxt_rdata = reg_rdata_ff;
		if (reg_rd) begin
			case (reg_addr)
				haptic_pkg::ADDR_LOOP_TUNING: nxt_rdata = tuning_ff;
				haptic_pkg::ADDR_OL_PERIOD:   nxt_rdata = {1'b0, ol_code_ff};
				haptic_pkg::ADDR_SUPPLY:      nxt_rdata = supply_code;
				haptic_pkg::ADDR_RESONANCE:   nxt_rdata = resonance_code;
				default:                      nxt_rdata = haptic_pkg::READ_ZERO;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			tuning_ff    <= haptic_pkg::LOOP_TUNING_RST;
			ol_code_ff   <= haptic_pkg::OL_PERIOD_RST[6:0];
			reg_rdata_ff <= haptic_pkg::READ_ZERO;
		end else begin
			tuning_ff    <= nxt_tuning;
			ol_code_ff   <= nxt_ol_code;
			reg_rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = reg_rdata_ff;

	// ----------------------------------------------------------------
	// live readings
	// ----------------------------------------------------------------
	// stale outside playback: host must read while a waveform runs
	sample_hold #(
		.W       (8),
		.RST_VAL (haptic_pkg::SUPPLY_RST)
	) u_supply (
		.sys_clk      (sys_clk),
		.reset        (reset),
		.host_load    (wr_supply),
		.host_data    (reg_wdata),
		.live         (play_active),
		.sample_valid (supply_sample_valid),
		.sample_data  (supply_sample),
		.value        (supply_code)
	);

	sample_hold #(
		.W       (8),
		.RST_VAL (haptic_pkg::RESONANCE_RST)
	) u_resonance (
		.sys_clk      (sys_clk),
		.reset        (reset),
		.host_load    (wr_resonance),
		.host_data    (reg_wdata),
		.live         (play_active),
		.sample_valid (resonance_sample_valid),
		.sample_data  (resonance_sample),
		.value        (resonance_code)
	);

	// ----------------------------------------------------------------
	// decoded controls
	// ----------------------------------------------------------------
	logic fell_back;

	assign fallback_attempt_count = {1'b0,
		tuning_ff[haptic_pkg::FB_CNT_MSB:haptic_pkg::FB_CNT_LSB]}
		+ haptic_pkg::FB_ATTEMPT_BASE;
	assign auto_fallback_enable = tuning_ff[haptic_pkg::FB_EN_BIT];
	assign blank_window_setting = {
		tuning_ff[haptic_pkg::BLANK_MSB:haptic_pkg::BLANK_LSB],
		blank_low_bits};
	assign dissipation_window_setting = {
		tuning_ff[haptic_pkg::DISS_MSB:haptic_pkg::DISS_LSB],
		diss_low_bits};
	assign open_loop_period_code = ol_code_ff;

	fallback_seq u_fallback (
		.sys_clk              (sys_clk),
		.reset                (reset),
		.play_active          (play_active),
		.lra_select           (lra_select),
		.auto_fallback_enable (auto_fallback_enable),
		.attempt_limit        (fallback_attempt_count),
		.sync_attempt_fail    (sync_attempt_fail),
		.bemf_detect          (bemf_detect),
		.fell_back            (fell_back)
	);

	// selected open loop and automatic fall-back share one period source
	assign open_loop_drive = lra_select && play_active &&
		(open_loop_select || fell_back);

	// ----------------------------------------------------------------
	// playback step timer
	// ----------------------------------------------------------------
	logic [STEP_W-1:0] step_cnt_ff;
	logic [STEP_W-1:0] nxt_step_cnt;
	logic [STEP_W-1:0] step_last;
	logic              step_tick_ff;
	logic              nxt_step_tick;

	assign step_last = tuning_ff[haptic_pkg::INTERVAL_BIT] ?
		STEP_W'(STEP_FAST_CYCLES - 1) : STEP_W'(STEP_SLOW_CYCLES - 1);

	always_comb begin
		nxt_step_cnt  = '0;
		nxt_step_tick = 1'b0;
		if (play_active) begin
			// interval change mid-step takes effect at once
			if (step_cnt_ff >= step_last) begin
				nxt_step_tick = 1'b1;
			end else begin
				nxt_step_cnt = step_cnt_ff + STEP_W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			step_cnt_ff  <= '0;
			step_tick_ff <= 1'b0;
		end else begin
			step_cnt_ff  <= nxt_step_cnt;
			step_tick_ff <= nxt_step_tick;
		end
	end

	assign playback_tick = step_tick_ff;

	// ----------------------------------------------------------------
	// open-loop period timer
	// ----------------------------------------------------------------
	logic [UNIT_W-1:0] unit_cnt_ff;
	logic [UNIT_W-1:0] nxt_unit_cnt;
	logic [6:0]        units_ff;
	logic [6:0]        nxt_units;
	logic              ol_tick_ff;
	logic              nxt_ol_tick;

	// code zero means no period: the timer stays idle and never ticks rather than spin
	always_comb begin
		nxt_unit_cnt = '0;
		nxt_units    = 7'h00;
		nxt_ol_tick  = 1'b0;
		if (open_loop_drive && ol_code_ff != 7'h00) begin
			nxt_units = units_ff;
			if (unit_cnt_ff == UNIT_W'(OL_UNIT_CYCLES - 1)) begin
				if (units_ff + 7'h01 >= ol_code_ff) begin
					nxt_units   = 7'h00;
					nxt_ol_tick = 1'b1;
				end else begin
					nxt_units = units_ff + 7'h01;
				end
			end else begin
				nxt_unit_cnt = unit_cnt_ff + UNIT_W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			unit_cnt_ff <= '0;
			units_ff    <= 7'h00;
			ol_tick_ff  <= 1'b0;
		end else begin
			unit_cnt_ff <= nxt_unit_cnt;
			units_ff    <= nxt_units;
			ol_tick_ff  <= nxt_ol_tick;
		end
	end

	assign ol_period_tick = ol_tick_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_attempt_decode: assert property (@(posedge sys_clk) disable iff (reset)
		reg_wr && reg_addr == haptic_pkg::ADDR_LOOP_TUNING |=>
		fallback_attempt_count == $past(reg_wdata[7:6]) + 3'h3)
		else $error("attempt count does not follow written code");
	chk_blank_upper: assert property (@(posedge sys_clk) disable iff (reset)
		reg_wr && reg_addr == haptic_pkg::ADDR_LOOP_TUNING |=>
		blank_window_setting[3:2] == $past(reg_wdata[3:2]))
		else $error("blanking upper bits wrong");
	chk_diss_upper: assert property (@(posedge sys_clk) disable iff (reset)
		reg_wr && reg_addr == haptic_pkg::ADDR_LOOP_TUNING |=>
		dissipation_window_setting[3:2] == $past(reg_wdata[1:0]))
		else $error("dissipation upper bits wrong");
	chk_low_join: assert property (@(posedge sys_clk) disable iff (reset)
		$stable(blank_low_bits) && $stable(diss_low_bits) |->
		blank_window_setting[1:0] == blank_low_bits &&
		dissipation_window_setting[1:0] == diss_low_bits)
		else $error("lower setting bits not joined");
	chk_ol_reserved: assert property (@(posedge sys_clk) disable iff (reset)
		reg_rd && reg_addr == haptic_pkg::ADDR_OL_PERIOD |=>
		!reg_rdata[7])
		else $error("reserved period bit reads one");
	chk_ol_tick_mode: assert property (@(posedge sys_clk) disable iff (reset)
		ol_period_tick |-> $past(open_loop_drive) &&
		$past(ol_code_ff) != 7'h00)
		else $error("open-loop tick outside open-loop drive");
	chk_step_length: assert property (@(posedge sys_clk) disable iff (reset)
		play_active && $past(play_active) && playback_tick &&
		$stable(tuning_ff[4]) |-> $past(step_cnt_ff) == step_last)
		else $error("playback step ended at wrong count");
	chk_supply_track: assert property (@(posedge sys_clk) disable iff (reset)
		play_active && supply_sample_valid |=>
		supply_code == $past(supply_sample))
		else $error("supply reading not refreshed");
	chk_reading_hold: assert property (@(posedge sys_clk) disable iff (reset)
		!play_active && !wr_supply && !wr_resonance |=>
		$stable(supply_code) && $stable(resonance_code))
		else $error("reading changed outside playback");
	chk_period_track: assert property (@(posedge sys_clk) disable iff (reset)
		play_active && resonance_sample_valid |=>
		resonance_code == $past(resonance_sample))
		else $error("resonance reading not refreshed");
	chk_fallback_drive: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(fell_back) && lra_select && play_active |-> open_loop_drive)
		else $error("fall-back did not select open loop");

	cov_fallback: cover property (@(posedge sys_clk) disable iff (reset)
		$rose(fell_back));
	cov_fast_step: cover property (@(posedge sys_clk) disable iff (reset)
		playback_tick && tuning_ff[4]);
	cov_ol_tick: cover property (@(posedge sys_clk) disable iff (reset)
		ol_period_tick && fell_back);
	cov_read_period: cover property (@(posedge sys_clk) disable iff (reset)
		reg_rd && reg_addr == haptic_pkg::ADDR_RESONANCE && play_active);
endmodule

// ---- tb/host_model.sv ----
// host side of the register port: byte writes and reads on sys_clk
// assumes the bench calls write_reg and read_reg one at a time
`timescale 1ns/100ps
module host_model (
	input  wire logic       sys_clk,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// ------------------------------------------------------------
	// bus cycles
	// ------------------------------------------------------------
	// released lines show the inverse so stale values never match
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule

// ---- tb/loop_tuning_regs_test.sv ----
// self-checking bench for the loop-tuning register bank
// assumes host_model drives the register port; engine inputs driven here
`timescale 1ns/100ps
module loop_tuning_regs_test;
	localparam int SLOW = 20;
	localparam int FAST = 4;
	localparam int OLU  = 4;

	logic       sys_clk = 1'b0;
	logic       reset = 1'b1;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       play = 1'b0;
	logic       lra = 1'b0;
	logic       ols = 1'b0;
	logic       fail = 1'b0;
	logic       bemf = 1'b0;
	logic [7:0] sup = 8'h00;
	logic       sup_v = 1'b0;
	logic [7:0] res = 8'h00;
	logic       res_v = 1'b0;
	logic [1:0] blo = 2'h0;
	logic [1:0] dlo = 2'h0;
	logic [2:0] att;
	logic       fb_en;
	logic       old;
	logic [6:0] olc;
	logic       ol_tick;
	logic       pb_tick;
	logic [3:0] blank;
	logic [3:0] diss;
	int         errors = 0;
	int         checks_done = 0;

	always #12.5 sys_clk = ~sys_clk;

	host_model host_u (.sys_clk(sys_clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));

	loop_tuning_regs #(.STEP_SLOW_CYCLES(SLOW), .STEP_FAST_CYCLES(FAST),
		.OL_UNIT_CYCLES(OLU)) dut_u (.sys_clk(sys_clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .play_active(play),
		.lra_select(lra), .open_loop_select(ols),
		.sync_attempt_fail(fail), .bemf_detect(bemf),
		.supply_sample(sup), .supply_sample_valid(sup_v),
		.resonance_sample(res), .resonance_sample_valid(res_v),
		.blank_low_bits(blo), .diss_low_bits(dlo),
		.fallback_attempt_count(att), .auto_fallback_enable(fb_en),
		.open_loop_drive(old), .open_loop_period_code(olc),
		.ol_period_tick(ol_tick), .playback_tick(pb_tick),
		.blank_window_setting(blank),
		.dissipation_window_setting(diss));

	// ------------------------------------------------------------
	// compare and report
	// ------------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check_val(input string what, input logic [7:0] got,
		input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_gap(input string what, input int exp, input int got);
		checks_done++;
		if (got != exp) begin
			errors++;
			$display("Error %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		host_u.read_reg(a, v);
		check_val("readback", v, exp);
	endtask

	// ------------------------------------------------------------
	// engine stimulus and expectations
	// ------------------------------------------------------------
	function automatic logic [7:0] exp_att(input logic [1:0] c);
		return {6'h00, c} + 8'h03;
	endfunction

	task automatic fails(input int k);
		repeat (k) begin
			@(negedge sys_clk);
			fail = 1'b1;
			@(negedge sys_clk);
			fail = 1'b0;
		end
	endtask

	task automatic bemf_pulse();
		@(negedge sys_clk);
		bemf = 1'b1;
		@(negedge sys_clk);
		bemf = 1'b0;
	endtask

	// cycles between two consecutive ticks, bounded both ways
	task automatic tick_gap(input bit ol, output int gap);
		int k;
		k = 0;
		gap = 0;
		while ((ol ? ol_tick : pb_tick) !== 1'b1 && k < 500) begin
			@(negedge sys_clk);
			k++;
		end
		do begin
			@(negedge sys_clk);
			gap++;
		end while ((ol ? ol_tick : pb_tick) !== 1'b1 && gap < 500);
		if (k >= 500 || gap >= 500) begin
			errors++;
			tally_and_finish();
		end
	endtask

	initial begin
		logic [7:0] d;
		int         g;
		int         i;
		void'($urandom(28));
		repeat (3) @(negedge sys_clk);
		reset = 1'b0;
		// reset values and unmapped space
		rd_chk(8'h1F, 8'h80);
		check_val("attempts", {5'h00, att}, 8'h05);
		check_val("fb_en", {7'h00, fb_en}, 8'h00);
		rd_chk(8'h20, 8'h00);
		rd_chk(8'h21, 8'h00);
		rd_chk(8'h22, 8'h00);
		host_u.write_reg(8'h10, 8'hFF);
		rd_chk(8'h10, 8'h00);
		// every attempt code with random fields and low halves
		for (i = 0; i < 8; i++) begin
			d = {i[1:0], 6'($urandom)};
			blo = 2'($urandom);
			dlo = 2'($urandom);
			host_u.write_reg(8'h1F, d);
			check_val("attempts", {5'h00, att}, exp_att(d[7:6]));
			check_val("fb_en", {7'h00, fb_en}, {7'h00, d[5]});
			check_val("blank", {4'h0, blank}, {4'h0, d[3:2], blo});
			check_val("diss", {4'h0, diss}, {4'h0, d[1:0], dlo});
			rd_chk(8'h1F, d);
		end
		// open-loop period, reserved bit dropped
		host_u.write_reg(8'h20, 8'h83);
		rd_chk(8'h20, 8'h03);
		check_val("ol_code", {1'b0, olc}, 8'h03);
		// samples ignored outside playback, taken during it
		host_u.write_reg(8'h21, 8'h33);
		rd_chk(8'h21, 8'h33);
		@(negedge sys_clk);
		sup = 8'h5A;
		sup_v = 1'b1;
		@(negedge sys_clk);
		sup_v = 1'b0;
		rd_chk(8'h21, 8'h33);
		play = 1'b1;
		sup = 8'($urandom);
		res = 8'($urandom);
		@(negedge sys_clk);
		sup_v = 1'b1;
		res_v = 1'b1;
		@(negedge sys_clk);
		sup_v = 1'b0;
		res_v = 1'b0;
		rd_chk(8'h21, sup);
		rd_chk(8'h22, res);
		// user open loop
		ols = 1'b1;
		lra = 1'b1;
		@(negedge sys_clk);
		check_val("ol_drive", {7'h00, old}, 8'h01);
		tick_gap(1'b1, g);
		check_gap("ol_period", 3 * OLU, g);
		ols = 1'b0;
		play = 1'b0;
		// fall-back after three attempts, count cleared by back-emf
		host_u.write_reg(8'h1F, 8'h20);
		play = 1'b1;
		fails(2);
		bemf_pulse();
		fails(2);
		@(negedge sys_clk);
		check_val("ol_drive", {7'h00, old}, 8'h00);
		fails(1);
		repeat (2) @(negedge sys_clk);
		check_val("ol_drive", {7'h00, old}, 8'h01);
		bemf_pulse();
		check_val("ol_drive", {7'h00, old}, 8'h01);
		tick_gap(1'b1, g);
		check_gap("ol_period", 3 * OLU, g);
		play = 1'b0;
		@(negedge sys_clk);
		check_val("ol_drive", {7'h00, old}, 8'h00);
		// enable clear: never falls back
		host_u.write_reg(8'h1F, 8'hC0);
		play = 1'b1;
		fails(8);
		repeat (2) @(negedge sys_clk);
		check_val("ol_drive", {7'h00, old}, 8'h00);
		play = 1'b0;
		lra = 1'b0;
		// playback step for both interval settings
		@(negedge sys_clk);
		play = 1'b1;
		tick_gap(1'b0, g);
		check_gap("step", SLOW, g);
		play = 1'b0;
		host_u.write_reg(8'h1F, 8'h10);
		play = 1'b1;
		tick_gap(1'b0, g);
		check_gap("step", FAST, g);
		tally_and_finish();
	end
endmodule
